//--- core/cpu_dma_bus_glue.v
// Glue between a processor bus and a 16-bit DMA controller
`timescale 1ns/1ns
`include "cpu_dma_bus_glue_regs.vh"

module cpu_dma_bus_glue #(
  parameter WR_WAIT_STATES = `GLUE_WR_WAIT_STATES,
  parameter RD_WAIT_STATES = `GLUE_RD_WAIT_STATES
) (
  // Clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // Processor bus cycle
  input wire i_address_strobe_n,
  input wire i_chip_select_n,
  input wire i_rw,
  input wire i_bus_error_n,
  output reg o_cycle_ack_n,
  // Processor byte strobes, two-way
  input wire i_upper_byte_strobe_n,
  input wire i_lower_byte_strobe_n,
  output wire o_upper_byte_strobe_n,
  output wire o_lower_byte_strobe_n,
  output wire o_byte_strobe_oe,
  // Processor bus exchange
  input wire i_grant_in_n,
  output reg o_cpu_bus_request_n,
  // DMA controller
  input wire i_dma_request,
  input wire i_dma_data_strobe_n,
  input wire i_byte_address_bit,
  input wire i_byte_word_select_n,
  output wire o_dma_ack,
  output reg o_strobe_to_dma_n,
  output reg o_end_of_process_n,
  // Data transceiver enables
  output reg o_receive_enable_n,
  output reg o_transmit_enable_n
);

  localparam [`GLUE_WAIT_CNT_W-1:0] WR_WAIT = WR_WAIT_STATES[`GLUE_WAIT_CNT_W-1:0];
  localparam [`GLUE_WAIT_CNT_W-1:0] RD_WAIT = RD_WAIT_STATES[`GLUE_WAIT_CNT_W-1:0];

  wire address_strobe;
  wire selected;
  wire cpu_byte_strobe;
  wire request_q;
  wire dma_owner;
  wire cpu_cycle;
  reg seen_q;
  reg [`GLUE_WAIT_CNT_W-1:0] wait_cnt_q;
  reg [`GLUE_WAIT_CNT_W-1:0] wait_cnt_d;
  wire [`GLUE_WAIT_CNT_W-1:0] wait_target;
  wire force_off;

  assign address_strobe = !i_address_strobe_n;
  assign selected = !i_chip_select_n;
  assign cpu_byte_strobe = !i_upper_byte_strobe_n || !i_lower_byte_strobe_n;
  // Request and acknowledge both high means the controller owns the bus
  assign dma_owner = i_dma_request && o_dma_ack;
  assign cpu_cycle = !o_dma_ack && selected && address_strobe && cpu_byte_strobe;

  //////////////////////////////////////////////////////////////////////////////
  // Bus exchange; only one extra master is arbitrated
  bus_exchange_fsm u_exchange (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_dma_request(i_dma_request),
    .i_grant_in(!i_grant_in_n),
    .i_address_strobe(address_strobe),
    .o_cpu_bus_request(request_q),
    .o_dma_ack(o_dma_ack)
  );

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cpu_bus_request_n <= !`GLUE_RST_REQUEST;
    end else begin
      // Raised before grant, held only while grant and address strobe both stand
      o_cpu_bus_request_n <= !((i_dma_request && !o_dma_ack && i_grant_in_n) ||
                               (request_q && i_dma_request && !i_grant_in_n &&
                                address_strobe));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte strobes while the controller is master
  dma_byte_strobes u_strobes (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_dma_owner(dma_owner),
    .i_dma_data_strobe(!i_dma_data_strobe_n),
    .i_byte_address_bit(i_byte_address_bit),
    .i_word_transfer(!i_byte_word_select_n),
    .o_upper_byte_strobe_n(o_upper_byte_strobe_n),
    .o_lower_byte_strobe_n(o_lower_byte_strobe_n),
    .o_strobe_oe(o_byte_strobe_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Strobe-seen flag and the strobe passed to the controller
  assign force_off = dma_owner || (!i_rw && seen_q);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_q <= `GLUE_RST_SEEN;
      o_strobe_to_dma_n <= `GLUE_RST_STROBE_N;
    end else begin
      seen_q <= cpu_byte_strobe && !o_dma_ack;
      // A write strobe lasts one clock; the processor holds data for the next
      o_strobe_to_dma_n <= !(cpu_cycle && !force_off);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cycle acknowledge with wait states counted per direction
  assign wait_target = i_rw ? RD_WAIT : WR_WAIT;

  always @* begin
    wait_cnt_d = wait_cnt_q;
    if (!cpu_cycle) begin
      wait_cnt_d = {`GLUE_WAIT_CNT_W{1'b0}};
    end else if (wait_cnt_q != wait_target) begin
      wait_cnt_d = wait_cnt_q + {{(`GLUE_WAIT_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_cnt_q <= {`GLUE_WAIT_CNT_W{1'b0}};
      o_cycle_ack_n <= 1'h1;
    end else begin
      wait_cnt_q <= wait_cnt_d;
      // Read acks at the first edge, write one edge later
      o_cycle_ack_n <= !(cpu_cycle && (wait_cnt_q == wait_target));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transceiver enables and end of process
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_receive_enable_n <= 1'h1;
      o_transmit_enable_n <= 1'h1;
      o_end_of_process_n <= 1'h1;
    end else begin
      o_receive_enable_n <= !(!o_dma_ack && selected && i_rw && cpu_byte_strobe);
      o_transmit_enable_n <= !(!o_dma_ack && selected && !i_rw);
      o_end_of_process_n <= !(dma_owner && !i_bus_error_n);
    end
  end

endmodule // cpu_dma_bus_glue

//--- core/cpu_dma_bus_glue_regs.vh
// Constants shared by the processor to DMA controller bus glue
`ifndef CPU_DMA_BUS_GLUE_REGS_VH
`define CPU_DMA_BUS_GLUE_REGS_VH

// Wait states added to a processor write of the DMA controller
`define GLUE_WR_WAIT_STATES 1
// Wait states added to a processor read of the DMA controller
`define GLUE_RD_WAIT_STATES 0
// Width of the wait-state counter
`define GLUE_WAIT_CNT_W 2

// Bus exchange state codes
`define GLUE_ST_W 2
`define GLUE_ST_IDLE 2'h0
`define GLUE_ST_REQUEST 2'h1
`define GLUE_ST_OWNED 2'h2

// Reset values of registered controls
`define GLUE_RST_REQUEST 1'h0
`define GLUE_RST_ACK 1'h0
`define GLUE_RST_SEEN 1'h0
`define GLUE_RST_STROBE_N 1'h1
`define GLUE_RST_OE 1'h0

`endif

//--- core/bus_exchange_fsm.v
// Bus exchange: two-wire DMA handshake to three-wire processor handshake
`timescale 1ns/1ns
`include "cpu_dma_bus_glue_regs.vh"

module bus_exchange_fsm (
  // Clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // Handshake inputs, active high
  input wire i_dma_request,
  input wire i_grant_in,
  input wire i_address_strobe,
  // Registered handshake outputs, active high
  output reg o_cpu_bus_request,
  output reg o_dma_ack
);

  localparam [`GLUE_ST_W-1:0] ST_IDLE = `GLUE_ST_IDLE;
  localparam [`GLUE_ST_W-1:0] ST_REQUEST = `GLUE_ST_REQUEST;
  localparam [`GLUE_ST_W-1:0] ST_OWNED = `GLUE_ST_OWNED;

  reg [`GLUE_ST_W-1:0] state_q;
  reg [`GLUE_ST_W-1:0] state_d;

  //////////////////////////////////////////////////////////////////////////////
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (i_dma_request && i_grant_in && !i_address_strobe) begin
          state_d = ST_OWNED;
        end else if (i_dma_request && !i_grant_in) begin
          state_d = ST_REQUEST;
        end
      end
      ST_REQUEST: begin
        if (!i_dma_request) begin
          state_d = ST_IDLE;
        end else if (i_grant_in && !i_address_strobe) begin
          state_d = ST_OWNED;
        end else begin
          // Held while request stands and grant waits on the strobe
          state_d = ST_REQUEST;
        end
      end
      ST_OWNED: begin
        // Acknowledge holds until the DMA request drops
        if (!i_dma_request) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      o_cpu_bus_request <= `GLUE_RST_REQUEST;
      o_dma_ack <= `GLUE_RST_ACK;
    end else begin
      state_q <= state_d;
      o_cpu_bus_request <= (state_d == ST_REQUEST);
      o_dma_ack <= (state_d == ST_OWNED);
    end
  end

endmodule // bus_exchange_fsm

//--- core/dma_byte_strobes.v
// Byte strobes driven onto the processor bus while the DMA controller is master
`timescale 1ns/1ns
`include "cpu_dma_bus_glue_regs.vh"

module dma_byte_strobes (
  // Clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // Ownership and DMA cycle information, active high
  input wire i_dma_owner,
  input wire i_dma_data_strobe,
  input wire i_byte_address_bit,
  input wire i_word_transfer,
  // Registered byte strobes with drive enable
  output reg o_upper_byte_strobe_n,
  output reg o_lower_byte_strobe_n,
  output reg o_strobe_oe
);

  wire upper_d;
  wire lower_d;

  assign upper_d = i_dma_data_strobe && (i_word_transfer || !i_byte_address_bit);
  assign lower_d = i_dma_data_strobe && (i_word_transfer || i_byte_address_bit);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_upper_byte_strobe_n <= `GLUE_RST_STROBE_N;
      o_lower_byte_strobe_n <= `GLUE_RST_STROBE_N;
      o_strobe_oe <= `GLUE_RST_OE;
    end else begin
      o_strobe_oe <= i_dma_owner;
      o_upper_byte_strobe_n <= !(i_dma_owner && upper_d);
      o_lower_byte_strobe_n <= !(i_dma_owner && lower_d);
    end
  end

endmodule // dma_byte_strobes

//--- dv/cpu_dma_bus_glue_chk.sv
// Assertion checker for the processor to DMA controller bus glue
`timescale 1ns/1ns
module cpu_dma_bus_glue_chk #(
  parameter WR_WAIT_STATES = 1,
  parameter RD_WAIT_STATES = 0
) (
  // Clock, reset and processor side
  input wire i_clk,
  input wire i_arst_n,
  input wire i_address_strobe_n,
  input wire i_chip_select_n,
  input wire i_rw,
  input wire i_upper_byte_strobe_n,
  input wire i_lower_byte_strobe_n,
  input wire i_grant_in_n,
  // DMA side
  input wire i_dma_request,
  input wire i_dma_data_strobe_n,
  input wire i_byte_word_select_n,
  // Outputs watched
  input wire o_cycle_ack_n,
  input wire o_upper_byte_strobe_n,
  input wire o_lower_byte_strobe_n,
  input wire o_byte_strobe_oe,
  input wire o_cpu_bus_request_n,
  input wire o_dma_ack,
  input wire o_strobe_to_dma_n,
  input wire o_receive_enable_n,
  input wire o_transmit_enable_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire cyc = !i_address_strobe_n && !i_chip_select_n && !o_dma_ack &&
    (!i_upper_byte_strobe_n || !i_lower_byte_strobe_n);
  wire wr_cyc = cyc && !i_rw;
  wire rd_cyc = cyc && i_rw;
  wire owner = i_dma_request && o_dma_ack;
  ////////////////////////////////////////////////////////////////////////////////
  rd_no_wait_a: assert property ($rose(rd_cyc) |=> !o_cycle_ack_n)
    else $error("read acknowledge late");
  wr_one_wait_a: assert property ($rose(wr_cyc) |=> o_cycle_ack_n ##1 !o_cycle_ack_n)
    else $error("write wait state wrong");
  wr_strobe_cut_a: assert property ($rose(wr_cyc) |=> !o_strobe_to_dma_n ##1 o_strobe_to_dma_n[*2])
    else $error("write strobe not shortened");
  req_raise_a: assert property (i_dma_request && !o_dma_ack && i_grant_in_n |=> !o_cpu_bus_request_n)
    else $error("bus request missing");
  req_hold_a: assert property (i_dma_request && !i_grant_in_n && !i_address_strobe_n &&
    !o_cpu_bus_request_n |=> !o_cpu_bus_request_n)
    else $error("bus request dropped early");
  req_drop_a: assert property (!i_dma_request |=> o_cpu_bus_request_n)
    else $error("bus request without dma request");
  ack_wait_a: assert property (!o_dma_ack && !i_address_strobe_n |=> !o_dma_ack)
    else $error("acknowledge while address strobe busy");
  ack_rise_a: assert property (i_dma_request && !i_grant_in_n && i_address_strobe_n |=> o_dma_ack)
    else $error("acknowledge missing");
  ack_keep_a: assert property (o_dma_ack |=> o_dma_ack == $past(i_dma_request))
    else $error("acknowledge hold wrong");
  owner_mute_a: assert property (owner |=> o_strobe_to_dma_n && o_receive_enable_n && o_transmit_enable_n)
    else $error("slave controls active while dma owns bus");
  rx_enable_a: assert property (rd_cyc |=> !o_receive_enable_n)
    else $error("receive enable missing");
  tx_enable_a: assert property (!o_dma_ack && !i_chip_select_n && !i_rw |=> !o_transmit_enable_n)
    else $error("transmit enable missing");
  word_strobes_a: assert property (owner && !i_dma_data_strobe_n && !i_byte_word_select_n |=>
    !o_upper_byte_strobe_n && !o_lower_byte_strobe_n && o_byte_strobe_oe)
    else $error("word strobes wrong");
  rst_clear_a: assert property (disable iff (1'b0) !i_arst_n |-> o_cpu_bus_request_n && !o_dma_ack)
    else $error("reset state wrong");
  cover property ($rose(wr_cyc));
  cover property ($rose(rd_cyc));
  cover property ($rose(owner));
endmodule // cpu_dma_bus_glue_chk

bind cpu_dma_bus_glue cpu_dma_bus_glue_chk #(.WR_WAIT_STATES(WR_WAIT_STATES),
  .RD_WAIT_STATES(RD_WAIT_STATES)) u_chk (.i_clk, .i_arst_n, .i_address_strobe_n,
  .i_chip_select_n, .i_rw, .i_upper_byte_strobe_n, .i_lower_byte_strobe_n, .i_grant_in_n,
  .i_dma_request, .i_dma_data_strobe_n, .i_byte_word_select_n, .o_cycle_ack_n,
  .o_upper_byte_strobe_n, .o_lower_byte_strobe_n, .o_byte_strobe_oe, .o_cpu_bus_request_n,
  .o_dma_ack, .o_strobe_to_dma_n, .o_receive_enable_n, .o_transmit_enable_n);

//--- dv/bus_host_model.sv
// Host arbiter model that answers the bus request with a grant
`timescale 1ns/1ns
module bus_host_model (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_slow,
  input wire i_cpu_bus_request_n,
  output reg o_grant_in_n
);
  reg [3:0] wait_q;
  // Sole arbiter: only one request source ever competes
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n || i_cpu_bus_request_n) begin
      wait_q <= 4'h0;
      o_grant_in_n <= 1'h1;
    end else if (wait_q >= (i_slow ? 4'h8 : 4'h1)) begin
      o_grant_in_n <= 1'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // bus_host_model

//--- dv/tb.sv
// Self-checking testbench for the processor to DMA controller bus glue
`timescale 1ns/1ns
`define check_eq(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  reg clk = 1'h0, arst_n = 1'h1, as_n = 1'h1, cs_n = 1'h1, rw = 1'h1, berr_n = 1'h1;
  reg cpu_uds_n = 1'h1, cpu_lds_n = 1'h1, dreq = 1'h0, dds_n = 1'h1, a0 = 1'h0, bw_n = 1'h1;
  reg slow = 1'h0;
  wire uds_w, lds_w, grant_n, cack_n, ou_n, ol_n, oe, dma_request_n, dack, sd_n, eop_n, rxe_n, txe_n;
  integer n_errors = 0, cmp_count = 0, i;
  assign uds_w = oe ? ou_n : cpu_uds_n;
  assign lds_w = oe ? ol_n : cpu_lds_n;
  always #5 clk = ~clk;
  cpu_dma_bus_glue DUT (.i_clk(clk), .i_arst_n(arst_n), .i_address_strobe_n(as_n),
    .i_chip_select_n(cs_n), .i_rw(rw), .i_bus_error_n(berr_n), .o_cycle_ack_n(cack_n),
    .i_upper_byte_strobe_n(uds_w), .i_lower_byte_strobe_n(lds_w), .o_upper_byte_strobe_n(ou_n),
    .o_lower_byte_strobe_n(ol_n), .o_byte_strobe_oe(oe), .i_grant_in_n(grant_n),
    .o_cpu_bus_request_n(dma_request_n), .i_dma_request(dreq), .i_dma_data_strobe_n(dds_n),
    .i_byte_address_bit(a0), .i_byte_word_select_n(bw_n), .o_dma_ack(dack),
    .o_strobe_to_dma_n(sd_n), .o_end_of_process_n(eop_n), .o_receive_enable_n(rxe_n),
    .o_transmit_enable_n(txe_n));
  bus_host_model u_host (.i_clk(clk), .i_arst_n(arst_n), .i_slow(slow),
    .i_cpu_bus_request_n(dma_request_n), .o_grant_in_n(grant_n));
  ////////////////////////////////////////////////////////////////////////////////
  task tick; begin @(posedge clk); #1; end endtask
  task cyc_on(input r, input u, input l);
    begin
      @(posedge clk);
      as_n <= 1'h0;
      cs_n <= 1'h0;
      rw <= r;
      cpu_uds_n <= u;
      cpu_lds_n <= l;
      tick;
    end
  endtask
  task cyc_off;
    begin
      @(posedge clk);
      {as_n, cs_n, rw, cpu_uds_n, cpu_lds_n} <= 5'h1F;
      repeat (2) @(posedge clk);
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_read;
    for (i = 0; i < 2; i = i + 1) begin
      cyc_on(1'h1, i[0], !i[0]);
      `check_eq(cack_n, 1'h0)
      `check_eq(rxe_n, 1'h0)
      cyc_off;
    end
  endtask
  task t_write;
    begin
      cyc_on(1'h0, 1'h1, 1'h0);
      `check_eq({sd_n, cack_n, txe_n}, 3'h2)
      tick;
      `check_eq({sd_n, cack_n}, 2'h2)
      tick;
      `check_eq(cack_n, 1'h0)
      cyc_off;
    end
  endtask
  task t_exchange;
    begin
      @(posedge clk);
      as_n <= 1'h0;
      dreq <= 1'h1;
      tick;
      `check_eq(dma_request_n, 1'h0)
      repeat (3) tick;
      `check_eq(dack, 1'h0)
      @(posedge clk);
      as_n <= 1'h1;
      for (i = 0; i < 8 && dack !== 1'h1; i = i + 1) tick;
      `check_eq({dack, dma_request_n}, 2'h3)
      tick;
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge clk);
        {bw_n, a0, dds_n, cs_n, rw} <= {i != 0, i == 2, 3'h0};
        tick;
        `check_eq({oe, ou_n, ol_n}, {1'h1, i == 2, i == 1})
        `check_eq({txe_n, sd_n}, 2'h3)
      end
      @(posedge clk);
      berr_n <= 1'h0;
      tick;
      `check_eq(eop_n, 1'h0)
      @(posedge clk);
      {dreq, berr_n, dds_n, cs_n, rw} <= 5'h0F;
      tick;
      `check_eq(dack, 1'h0)
      tick;
      `check_eq(oe, 1'h0)
    end
  endtask
  task t_abort;
    begin
      @(posedge clk);
      {slow, dreq} <= 2'h3;
      repeat (3) tick;
      `check_eq({dma_request_n, dack}, 2'h0)
      @(posedge clk);
      dreq <= 1'h0;
      tick;
      `check_eq({dma_request_n, dack}, 2'h2)
    end
  endtask
  initial begin
    arst_n <= 1'h0;
    repeat (20) @(posedge clk);
    `check_eq({dma_request_n, dack, sd_n}, 3'h5)
    arst_n <= 1'h1;
    t_read;
    t_write;
    t_exchange;
    t_abort;
    t_write;
    conclude;
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_errors = n_errors + 1;
    conclude;
  end
endmodule // tb
